// file: logic/dsp_defines.vh
// Register map, field positions and reset values of the serial port
`ifndef DSP_DEFINES_VH
`define DSP_DEFINES_VH
`define DSP_ADDR_ASYNC_MODE 16'hff70
`define DSP_ADDR_ERR_STAT   16'hff71
`define DSP_ADDR_SYNC_MODE  16'hff72
`define DSP_ADDR_BAUD_CTRL  16'hff73
`define DSP_ADDR_DATA       16'hff74
`define DSP_AM_TX_EN        7
`define DSP_AM_RX_EN        6
`define DSP_AM_PAR_HI       5
`define DSP_AM_PAR_LO       4
`define DSP_AM_CHAR_LEN     3
`define DSP_AM_STOP_LEN     2
`define DSP_SM_ENABLE       7
`define DSP_SM_LSB_FIRST    2
`define DSP_SM_CLK_INT      1
`define DSP_ES_PARITY       2
`define DSP_ES_FRAMING      1
`define DSP_ES_OVERRUN      0
`define DSP_RST_MODE        8'h00
`define DSP_RST_ERR         3'h0
`define DSP_RST_TX_DATA     8'hff
`define DSP_RST_BAUD        8'h00
`define DSP_SYNC_BITS       4'h8
`endif

// file: logic/dsp_serial_port.v
// Dual-mode serial port: asynchronous UART or 3-wire clocked serial port
`timescale 1ns/100ps
`include "dsp_defines.vh"
// What this block does
// - A write of the data register starts a transfer at once.
// - Seven-bit characters send bits 0 to 6 only, bit 7 ignored.
// - Transmit data register is write-only, byte-wide, resets to all ones.
// - Data address reads the receive buffer and writes the transmit register.
// - Serial input shifts into a hidden stage, then into the buffer.
// - Seven-bit reception clears buffer bit 7.
// - Receive buffer is read-only, byte-wide, undefined after reset.
// - Async frames get start bit, optional parity and stop bits.
// - Async receiver checks errors and records them in error status.
// - Sync mode bit 7 enables, bit 2 picks LSB first; resets zero.
// - Sync mode bit 1 picks internal clock, else external clock pin.
// - Async mode bit 7 enables transmit, bit 6 receive; resets zero.
// - Parity field: none, zero bit unchecked, odd, even.
// - Length bit picks seven or eight bits; stop bit picks one or two.
// - Async transmit and receive run independently at the same time.
// - Three-wire mode exchanges eight bits, shifting out and in together.
// - All enables clear stops the port and frees its pins.
// - Parity and framing errors flagged; error status resets zero.
module dsp_serial_port (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  // Register port
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // Serial pins
  input  wire        i_rxd,
  output reg         o_txd,
  output reg         o_txd_oe,
  input  wire        i_sck,
  output reg         o_sck,
  output reg         o_sck_oe,
  // Events and state
  output reg         o_tx_done,
  output reg         o_rx_done,
  output reg         o_sync_done,
  output reg         o_port_stopped
);
  localparam [1:0] RX_IDLE  = 2'd0;
  localparam [1:0] RX_START = 2'd1;
  localparam [1:0] RX_BITS  = 2'd2;
  localparam [1:0] RX_STOP  = 2'd3;
  reg  [7:0]  amode_q;
  reg  [7:0]  smode_q;
  reg  [7:0]  baud_q;
  reg  [7:0]  tx_data_q;
  reg  [7:0]  rx_buf_q;
  reg         rx_full_q;
  reg  [2:0]  err_q;
  reg  [2:0]  rxd_sync_q;
  reg  [2:0]  sck_sync_q;
  reg         rxd_f_q;
  reg         sck_f_q;
  reg         sck_f_prev_q;
  // Async transmitter
  reg         tx_busy_q;
  reg  [11:0] tx_frame_q;
  reg  [3:0]  tx_left_q;
  reg  [11:0] tx_tmr_q;
  // Async receiver
  reg  [1:0]  rx_st_q;
  reg  [8:0]  rx_sh_q;
  reg  [3:0]  rx_cnt_q;
  reg  [11:0] rx_tmr_q;
  // Three-wire engine
  reg         sy_busy_q;
  reg  [7:0]  sy_sh_q;
  reg  [3:0]  sy_cnt_q;
  reg  [10:0] sy_tmr_q;
  wire        tx_en    = amode_q[`DSP_AM_TX_EN];
  wire        rx_en    = amode_q[`DSP_AM_RX_EN];
  wire [1:0]  par_sel  = amode_q[`DSP_AM_PAR_HI:`DSP_AM_PAR_LO];
  wire        len8     = amode_q[`DSP_AM_CHAR_LEN];
  wire        stop2    = amode_q[`DSP_AM_STOP_LEN];
  wire        sy_en    = smode_q[`DSP_SM_ENABLE];
  wire        sy_lsb   = smode_q[`DSP_SM_LSB_FIRST];
  wire        sy_int   = smode_q[`DSP_SM_CLK_INT];
  wire        par_on   = (par_sel != 2'b00);
  wire [11:0] bit_lim  = {baud_q, 4'hf};
  wire [11:0] half_lim = {1'b0, baud_q, 3'h7};
  wire        wr_data  = i_wr && (i_addr == `DSP_ADDR_DATA);
  wire        rd_data  = i_rd && (i_addr == `DSP_ADDR_DATA);
  wire        rd_err   = i_rd && (i_addr == `DSP_ADDR_ERR_STAT);
  // Transmit frame, LSB first, idle ones above the stop bits
  wire [7:0]  tx_chr   = len8 ? i_wdata : {1'b0, i_wdata[6:0]};
  wire        tx_par   = (par_sel == 2'b10) ? ~^tx_chr :
                         (par_sel == 2'b11) ? ^tx_chr : 1'b0;
  wire        tx_pb    = par_on ? tx_par : 1'b1;
  wire [8:0]  tx_pay   = len8 ? {tx_pb, tx_chr} : {1'b1, tx_pb, tx_chr[6:0]};
  wire [3:0]  tx_nbits = 4'd9 + {3'b000, len8} + {3'b000, par_on} +
                         {3'b000, stop2};
  // Receive alignment of the hidden shift stage
  wire [3:0]  rx_n     = 4'd7 + {3'b000, len8} + {3'b000, par_on};
  wire [8:0]  rx_al    = rx_sh_q >> (4'd9 - rx_n);
  wire [7:0]  rx_chr   = len8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
  wire        rx_pb    = len8 ? rx_al[8] : rx_al[7];
  wire        rx_perr  = par_sel[1] &&
                         ((^{rx_chr, rx_pb}) == par_sel[0]);
  // Three-wire clock edges, internal or external source
  wire        sy_fall  = sy_int ? (sy_tmr_q == half_lim[10:0] && o_sck)
                                : (sck_f_prev_q && !sck_f_q);
  wire        sy_rise  = sy_int ? (sy_tmr_q == half_lim[10:0] && !o_sck)
                                : (!sck_f_prev_q && sck_f_q);
  wire        sy_out   = sy_lsb ? sy_sh_q[0] : sy_sh_q[7];
  // Pin synchronisers, a change counts once stages two and three agree
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rxd_sync_q   <= 3'h7;
      sck_sync_q   <= 3'h7;
      rxd_f_q      <= 1'b1;
      sck_f_q      <= 1'b1;
      sck_f_prev_q <= 1'b1;
    end else begin
      rxd_sync_q   <= {rxd_sync_q[1:0], i_rxd};
      sck_sync_q   <= {sck_sync_q[1:0], i_sck};
      if (rxd_sync_q[1] == rxd_sync_q[2]) begin
        rxd_f_q <= rxd_sync_q[2];
      end
      if (sck_sync_q[1] == sck_sync_q[2]) begin
        sck_f_q <= sck_sync_q[2];
      end
      sck_f_prev_q <= sck_f_q;
    end
  end
  // Software registers and register reads
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      amode_q   <= `DSP_RST_MODE;
      smode_q   <= `DSP_RST_MODE;
      baud_q    <= `DSP_RST_BAUD;
      tx_data_q <= `DSP_RST_TX_DATA;
      o_rdata   <= 8'h00;
    end else begin
      if (i_wr) begin
        if (i_addr == `DSP_ADDR_ASYNC_MODE) begin
          amode_q <= i_wdata;
        end else if (i_addr == `DSP_ADDR_SYNC_MODE) begin
          smode_q <= i_wdata;
        end else if (i_addr == `DSP_ADDR_BAUD_CTRL) begin
          baud_q <= i_wdata;
        end else if (i_addr == `DSP_ADDR_DATA) begin
          tx_data_q <= i_wdata;
        end
      end
      o_rdata <= 8'h00;
      if (i_rd) begin
        if (i_addr == `DSP_ADDR_ASYNC_MODE) begin
          o_rdata <= amode_q;
        end else if (i_addr == `DSP_ADDR_SYNC_MODE) begin
          o_rdata <= smode_q;
        end else if (i_addr == `DSP_ADDR_BAUD_CTRL) begin
          o_rdata <= baud_q;
        end else if (i_addr == `DSP_ADDR_ERR_STAT) begin
          o_rdata <= {5'h00, err_q};
        end else if (i_addr == `DSP_ADDR_DATA) begin
          o_rdata <= rx_buf_q;
        end
      end
    end
  end
  // Async transmitter, starts on the data write itself
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_busy_q  <= 1'b0;
      tx_frame_q <= 12'hfff;
      tx_left_q  <= 4'h0;
      tx_tmr_q   <= 12'h000;
      o_tx_done  <= 1'b0;
    end else begin
      o_tx_done <= 1'b0;
      if (!tx_en || sy_en) begin
        tx_busy_q  <= 1'b0;
        tx_frame_q <= 12'hfff;
      end else if (wr_data && !tx_busy_q) begin
        tx_busy_q  <= 1'b1;
        tx_frame_q <= {2'b11, tx_pay, 1'b0};
        tx_left_q  <= tx_nbits;
        tx_tmr_q   <= 12'h000;
      end else if (tx_busy_q) begin
        if (tx_tmr_q == bit_lim) begin
          tx_tmr_q   <= 12'h000;
          tx_frame_q <= {1'b1, tx_frame_q[11:1]};
          tx_left_q  <= tx_left_q - 4'd1;
          if (tx_left_q == 4'd1) begin
            tx_busy_q <= 1'b0;
            o_tx_done <= 1'b1;
          end
        end else begin
          tx_tmr_q <= tx_tmr_q + 12'd1;
        end
      end
    end
  end
  // Async receiver, samples each bit in its middle
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_st_q  <= RX_IDLE;
      rx_sh_q  <= 9'h000;
      rx_cnt_q <= 4'h0;
      rx_tmr_q <= 12'h000;
    end else if (!rx_en || sy_en) begin
      rx_st_q <= RX_IDLE;
    end else begin
      rx_tmr_q <= rx_tmr_q + 12'd1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_tmr_q <= 12'h000;
          if (!rxd_f_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tmr_q == half_lim) begin
            rx_tmr_q <= 12'h000;
            rx_cnt_q <= 4'h0;
            rx_st_q  <= rxd_f_q ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_tmr_q == bit_lim) begin
            rx_tmr_q <= 12'h000;
            rx_sh_q  <= {rxd_f_q, rx_sh_q[8:1]};
            rx_cnt_q <= rx_cnt_q + 4'd1;
            if (rx_cnt_q == rx_n - 4'd1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        default: begin
          if (rx_tmr_q == bit_lim) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end
  // Three-wire engine, out on falling edge, in on rising edge
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sy_busy_q   <= 1'b0;
      sy_sh_q     <= 8'h00;
      sy_cnt_q    <= 4'h0;
      sy_tmr_q    <= 11'h000;
      o_sck       <= 1'b1;
      o_sync_done <= 1'b0;
    end else begin
      o_sync_done <= 1'b0;
      if (!sy_en) begin
        sy_busy_q <= 1'b0;
        o_sck     <= 1'b1;
      end else if (wr_data && !sy_busy_q) begin
        sy_busy_q <= 1'b1;
        sy_sh_q   <= i_wdata;
        sy_cnt_q  <= 4'h0;
        sy_tmr_q  <= 11'h000;
      end else if (sy_busy_q) begin
        sy_tmr_q <= (sy_tmr_q == half_lim[10:0]) ? 11'h000 : sy_tmr_q + 11'd1;
        if (sy_int && sy_tmr_q == half_lim[10:0]) begin
          o_sck <= ~o_sck;
        end
        if (sy_rise) begin
          sy_sh_q  <= sy_lsb ? {rxd_f_q, sy_sh_q[7:1]}
                             : {sy_sh_q[6:0], rxd_f_q};
          sy_cnt_q <= sy_cnt_q + 4'd1;
          if (sy_cnt_q == `DSP_SYNC_BITS - 4'd1) begin
            sy_busy_q   <= 1'b0;
            o_sync_done <= 1'b1;
          end
        end
      end
    end
  end
  // Serial data out and pin ownership
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_txd          <= 1'b1;
      o_txd_oe       <= 1'b0;
      o_sck_oe       <= 1'b0;
      o_port_stopped <= 1'b1;
    end else begin
      if (sy_en) begin
        if ((!sy_busy_q && wr_data) || (sy_busy_q && sy_fall)) begin
          o_txd <= sy_busy_q ? sy_out :
                   (sy_lsb ? i_wdata[0] : i_wdata[7]);
        end
      end else begin
        o_txd <= tx_frame_q[0];
      end
      o_txd_oe       <= tx_en || sy_en;
      o_sck_oe       <= sy_en && sy_int;
      o_port_stopped <= !tx_en && !rx_en && !sy_en;
    end
  end
  // Receive buffer, error status and receive event
  always @(posedge i_ref_clk) begin
    if (rx_st_q == RX_STOP && rx_tmr_q == bit_lim && rx_en && !sy_en) begin
      rx_buf_q <= rx_chr;
    end else if (sy_rise && sy_busy_q && sy_en &&
                 sy_cnt_q == `DSP_SYNC_BITS - 4'd1) begin
      rx_buf_q <= sy_lsb ? {rxd_f_q, sy_sh_q[7:1]}
                         : {sy_sh_q[6:0], rxd_f_q};
    end
  end
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      err_q     <= `DSP_RST_ERR;
      rx_full_q <= 1'b0;
      o_rx_done <= 1'b0;
    end else begin
      o_rx_done <= 1'b0;
      if (rd_err) begin
        err_q <= `DSP_RST_ERR;
      end
      if (rd_data) begin
        rx_full_q <= 1'b0;
      end
      // Set wins over the read that clears
      if (rx_st_q == RX_STOP && rx_tmr_q == bit_lim && rx_en && !sy_en) begin
        o_rx_done <= 1'b1;
        rx_full_q <= 1'b1;
        err_q     <= (rd_err ? 3'h0 : err_q) |
                     {rx_perr, !rxd_f_q, rx_full_q && !rd_data};
      end
    end
  end
endmodule

// file: tb/dsp_serial_port_properties.sv
// Checker of bus, line and event timing of the serial port
`timescale 1ns/100ps
module dsp_serial_port_chk (
  // Clock, reset and register port
  input wire        i_ref_clk,
  input wire        i_rst_b,
  input wire [15:0] i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  // Pins and events
  input wire        o_txd,
  input wire        o_txd_oe,
  input wire        o_sck_oe,
  input wire        o_tx_done,
  input wire        o_sync_done,
  input wire        o_port_stopped
);
  reg  [7:0] am_q;
  reg  [7:0] sm_q;
  reg        bz_q;
  wire       go = i_wr && i_addr == 16'hff74 && !bz_q &&
                  (am_q[7] | sm_q[7]);
  // Shadow of mode registers and transfer busy
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      am_q <= 8'h00;
      sm_q <= 8'h00;
      bz_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == 16'hff70) am_q <= i_wdata;
      if (i_wr && i_addr == 16'hff72) sm_q <= i_wdata;
      bz_q <= go | (bz_q & !(o_tx_done | o_sync_done));
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Bus, line and event relations
  rd_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  tx_start_a: assert property (
    go && am_q[7] && !sm_q[7] |=> ##1 !o_txd [*8]) else $error("no start");
  sync_first_a: assert property (
    go && sm_q[7] |=> o_txd ==
    (sm_q[2] ? $past(i_wdata[0]) : $past(i_wdata[7])))
    else $error("wrong first bit");
  tx_stop_a: assert property (
    o_tx_done |-> o_txd && $past(o_txd, 8)) else $error("stop low");
  rx_seven_a: assert property (
    $past(i_rd) && $past(i_addr) == 16'hff74 && !am_q[3] && !sm_q[7]
    |-> !o_rdata[7]) else $error("bit 7 set");
  err_rsvd_a: assert property (
    $past(i_rd) && $past(i_addr) == 16'hff71 |-> o_rdata[7:3] == 5'h00)
    else $error("status high bits set");
  sck_oe_a: assert property (
    sm_q[7] && sm_q[1] && $stable(sm_q) |-> o_sck_oe)
    else $error("clock not driven");
  stop_idle_a: assert property (
    !am_q[7] && !am_q[6] && !sm_q[7] && $stable(am_q) && $stable(sm_q)
    |-> o_port_stopped && !o_txd_oe) else $error("port not stopped");
endmodule
bind dsp_serial_port dsp_serial_port_chk dsp_serial_port_chk_i (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_sck_oe(o_sck_oe),
  .o_tx_done(o_tx_done), .o_sync_done(o_sync_done),
  .o_port_stopped(o_port_stopped));

// file: tb/dsp_peer.sv
// Far side: UART peer and 3-wire device with its own clock
`timescale 1ns/100ps
module dsp_peer (
  // Clock and echo select
  input  wire  i_ref_clk,
  input  wire  i_txd,
  input  wire  i_loop,
  // Lines toward the port
  output logic o_rxd,
  output logic o_sck
);
  logic line_q = 1'b1;
  // Echo in 3-wire use, own frames otherwise; idle line is mark
  assign o_rxd = i_loop ? i_txd : line_q;
  initial o_sck = 1'b1;
  // One frame, first bit first, 16 cycles a bit
  task automatic send(input [12:0] f, input integer n);
    integer k;
    for (k = 0; k < n; k++) begin
      line_q <= f[k];
      repeat (16) @(posedge i_ref_clk);
    end
    line_q <= 1'b1;
  endtask
  // Eight clock pulses, ending on the last rising edge
  task automatic clk8;
    repeat (8) begin
      repeat (20) @(posedge i_ref_clk);
      o_sck <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      o_sck <= 1'b1;
    end
  endtask
endmodule

// file: tb/test_dsp_serial_port.sv
// Self-checking bench of the dual-mode serial port
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_dsp_serial_port;
  // Stimulus and observed signals
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        loop = 1'b0;
  wire  [7:0]  o_rdata;
  wire         i_rxd, i_sck, o_txd, o_txd_oe, o_sck, o_sck_oe;
  wire         o_tx_done, o_rx_done, o_sync_done, o_port_stopped;
  wire  [2:0]  ev = {o_sync_done, o_rx_done, o_tx_done};
  integer      fail_count = 0;
  integer      compares = 0;
  integer      i, k, n;
  logic [7:0]  d;
  logic [3:0]  m;
  logic [12:0] f, g;
  always #50 i_ref_clk = ~i_ref_clk;
  dsp_serial_port dsp_serial_port_i (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_txd_oe(o_txd_oe), .i_sck(i_sck), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .o_tx_done(o_tx_done), .o_rx_done(o_rx_done),
    .o_sync_done(o_sync_done), .o_port_stopped(o_port_stopped));
  dsp_peer dsp_peer_i (.i_ref_clk(i_ref_clk), .i_txd(o_txd),
    .i_loop(loop), .o_rxd(i_rxd), .o_sck(i_sck));
  // Expected frame: start, data, parity, then ones
  function automatic [12:0] frm(input [7:0] v, input [3:0] md);
    integer j;
    frm = 13'h1ffe;
    for (j = 0; j < 7 + md[1]; j++) frm[j + 1] = v[j];
    if (md[3:2] != 2'b00)
      frm[8 + md[1]] = md[3] & (^v[6:0] ^ (md[1] & v[7]) ^ ~md[2]);
  endfunction
  // Bus write and checked read
  task automatic wr(input [15:0] a, input [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input [15:0] a, input [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  // Bounded wait for one event pulse
  task automatic wt(input integer s);
    integer c;
    c = 0;
    do begin
      @(posedge i_ref_clk);
      #1 c++;
    end while (ev[s] !== 1'b1 && c < 400);
    if (c >= 400) begin
      fail_count++;
      conclude;
    end
  endtask
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset values, then full-duplex frames, then 3-wire exchanges
  initial begin
    void'($urandom(32'h32b0b56a));
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rdc(16'hff70, 8'h00);
    rdc(16'hff72, 8'h00);
    rdc(16'hff71, 8'h00);
    rdc(16'hff7f, 8'h00);
    `CHK(o_port_stopped, 1'b1)
    wr(16'hff73, 8'h00);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      m = $urandom;
      d = $urandom;
      if (i < 4) m[3:2] = i[1:0];
      if (i == 4 || i == 5) m[3] = 1'b1;
      n = 9 + m[1] + (m[3:2] != 2'b00) + m[0];
      g = frm(d, m);
      f = g;
      if (i == 4 || i == 5) f[8 + m[1]] = ~f[8 + m[1]];
      if (i > 5) f[n - 1 - m[0]] = 1'b0;
      wr(16'hff70, {2'b11, m, 2'b00});
      rdc(16'hff70, {2'b11, m, 2'b00});
      wr(16'hff74, d);
      fork
        begin
          repeat (9) @(posedge i_ref_clk);
          for (k = 0; k < n; k++) begin
            if (k > 0) repeat (16) @(posedge i_ref_clk);
            #1 `CHK(o_txd, g[k])
          end
          wt(0);
        end
        dsp_peer_i.send(f, n);
        wt(1);
      join
      rdc(16'hff74, m[1] ? d : {1'b0, d[6:0]});
      rdc(16'hff71, {5'h00, (i == 4 || i == 5), (i > 5), 1'b0});
      wr(16'hff70, 8'h00);
      $display("test async %0d done", i);
    end
    loop <= 1'b1;
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      wr(16'hff72, {4'h8, 1'b0, i[0], i[1], 1'b0});
      wr(16'hff74, d);
      @(posedge i_ref_clk);
      #1 `CHK(o_txd, i[0] ? d[0] : d[7])
      `CHK({o_sck_oe, o_sck, o_txd_oe}, {i[1], 2'b11})
      if (!i[1]) dsp_peer_i.clk8();
      wt(2);
      rdc(16'hff74, d);
      wr(16'hff72, 8'h00);
      $display("test sync %0d done", i);
    end
    repeat (3) @(posedge i_ref_clk);
    #1 `CHK(o_port_stopped, 1'b1)
    conclude;
  end
endmodule
